// ### verilog/mux_sram_host.sv
// Host end: sequences address latching and byte reads and writes
`timescale 1ns/100ps
`default_nettype none
module mux_sram_host (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_skip_hi,
  input  wire logic        i_skip_lo,
  input  wire logic        i_hi_first,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  mux_sram_if.host         bus
);
  typedef enum logic [2:0] {
    IDLE, ADDR1, ADDR2, DSETUP, STROBE, RELEASE
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t   fsm;
    logic [4:0]  cnt;
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        skip_hi;
    logic        skip_lo;
    logic        hi_first;
    logic        las_n;
    logic        has_n;
    logic        rd_n;
    logic        wr_n;
    logic        ce_n;
    logic [7:0]  out;
    logic        oe_n;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
  } host_state_t;

  host_state_t s_reg;
  host_state_t s_next;
  logic        cur_hi;

  // Which byte the current address phase carries
  assign cur_hi = (s_reg.fsm == ADDR1) ? s_reg.hi_first : !s_reg.hi_first;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.cnt = s_reg.cnt + 5'h01;
    case (s_reg.fsm)
      IDLE: begin
        s_next.cnt = '0;
        if (i_req) begin
          s_next = s_reg;
          s_next.done = 1'b0;
          s_next.cnt = '0;
          s_next.wr = i_write;
          s_next.addr = i_addr;
          s_next.wdata = i_wdata;
          s_next.skip_hi = i_skip_hi;
          s_next.skip_lo = i_skip_lo;
          s_next.hi_first = i_hi_first;
          s_next.busy = 1'b1;
          s_next.ce_n = 1'b0;
          s_next.fsm = ADDR1;
        end
      end
      ADDR1, ADDR2: begin
        // Skipped byte keeps the device's previous latch
        if ((cur_hi && s_reg.skip_hi) || (!cur_hi && s_reg.skip_lo)) begin
          s_next.cnt = '0;
          s_next.fsm = (s_reg.fsm == ADDR1) ? ADDR2 : DSETUP;
        end else begin
          s_next.oe_n = 1'b0;
          s_next.out = cur_hi ? {3'h0, s_reg.addr[12:8]} : s_reg.addr[7:0];
          if (s_reg.cnt == 5'(mux_sram_pkg::T_AS_CYC)) begin
            s_next.las_n = cur_hi ? 1'b1 : 1'b0;
            s_next.has_n = cur_hi ? 1'b0 : 1'b1;
          end
          if (s_reg.cnt == 5'(mux_sram_pkg::T_AS_CYC
                              + mux_sram_pkg::T_ASL_CYC)) begin
            s_next.las_n = 1'b1;
            s_next.has_n = 1'b1;
          end
          if (s_reg.cnt == 5'(mux_sram_pkg::T_AS_CYC
                              + mux_sram_pkg::T_ASL_CYC + 1)) begin
            s_next.oe_n = 1'b1;
            s_next.cnt = '0;
            s_next.fsm = (s_reg.fsm == ADDR1) ? ADDR2 : DSETUP;
          end
        end
      end
      DSETUP: begin
        s_next.oe_n = !s_reg.wr;
        s_next.out = s_reg.wdata;
        if (!s_reg.wr || s_reg.cnt == 5'(mux_sram_pkg::T_DS_CYC)) begin
          s_next.cnt = '0;
          // Only one of the two strobes at a time
          s_next.wr_n = !s_reg.wr;
          s_next.rd_n = s_reg.wr;
          s_next.fsm = STROBE;
        end
      end
      STROBE: begin
        if (s_reg.cnt == 5'(s_reg.wr ? mux_sram_pkg::T_WLWH_CYC
                                    : mux_sram_pkg::T_RLRH_CYC)) begin
          if (!s_reg.wr) begin
            s_next.rdata = bus.shared_addr_data_bus;
          end
          s_next.wr_n = 1'b1;
          s_next.rd_n = 1'b1;
          s_next.cnt = '0;
          s_next.fsm = RELEASE;
        end
      end
      RELEASE: begin
        s_next.oe_n = 1'b1;
        s_next.ce_n = 1'b1;
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.fsm = IDLE;
      end
      default: begin
        s_next.fsm = IDLE;
      end
    endcase
    if (i_srst) begin
      s_next = '0;
      s_next.fsm = IDLE;
      s_next.las_n = 1'b1;
      s_next.has_n = 1'b1;
      s_next.rd_n = 1'b1;
      s_next.wr_n = 1'b1;
      s_next.ce_n = 1'b1;
      s_next.oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    s_reg <= s_next;
  end

  assign bus.low_addr_strobe_n  = s_reg.las_n;
  assign bus.high_addr_strobe_n = s_reg.has_n;
  assign bus.read_strobe_n      = s_reg.rd_n;
  assign bus.write_strobe_n     = s_reg.wr_n;
  assign bus.chip_enable_n      = s_reg.ce_n;
  assign bus.host_bus_out       = s_reg.out;
  assign bus.host_bus_oe_n      = s_reg.oe_n;
  assign o_busy  = s_reg.busy;
  assign o_done  = s_reg.done;
  assign o_rdata = s_reg.rdata;
endmodule
`default_nettype wire

// ### verilog/mux_sram_pkg.sv
// Shared constants for the multiplexed address/data byte-wide RAM port
`default_nettype none
package mux_sram_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned LO_ADDR_W   = 8;
  localparam int unsigned HI_ADDR_W   = 5;
  localparam int unsigned ADDR_W      = LO_ADDR_W + HI_ADDR_W;
  localparam int unsigned MEM_DEPTH   = 1 << ADDR_W;
  // Pin timing figures in ns, turned into 4 ns clock cycles
  localparam int unsigned CLK_NS      = 4;
  localparam int unsigned T_AS_NS     = 20;
  localparam int unsigned T_DS_NS     = 60;
  localparam int unsigned T_ASL_NS    = 15;
  localparam int unsigned T_RLRH_NS   = 70;
  localparam int unsigned T_WLWH_NS   = 50;
  localparam int unsigned T_AS_CYC    = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_DS_CYC    = (T_DS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_ASL_CYC   = (T_ASL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_RLRH_CYC  = (T_RLRH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_WLWH_CYC  = (T_WLWH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W       = 5;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
endpackage
`default_nettype wire

// ### verilog/mux_sram_if.sv
// Pin bundle between the host and the multiplexed address/data RAM
`timescale 1ns/100ps
`default_nettype none
interface mux_sram_if;
  logic       low_addr_strobe_n;
  logic       high_addr_strobe_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       chip_enable_n;
  logic [7:0] host_bus_out;
  logic       host_bus_oe_n;
  logic [7:0] dev_bus_out;
  logic       dev_bus_oe_n;
  logic [7:0] shared_addr_data_bus;

  // Wire level resolved from both drivers; an undriven bus floats high
  always_comb begin
    if (!dev_bus_oe_n) begin
      shared_addr_data_bus = dev_bus_out;
    end else if (!host_bus_oe_n) begin
      shared_addr_data_bus = host_bus_out;
    end else begin
      shared_addr_data_bus = 8'hff;
    end
  end

  modport device (
    input  low_addr_strobe_n, high_addr_strobe_n, read_strobe_n,
    input  write_strobe_n, chip_enable_n, shared_addr_data_bus,
    output dev_bus_out, dev_bus_oe_n
  );
  modport host (
    output low_addr_strobe_n, high_addr_strobe_n, read_strobe_n,
    output write_strobe_n, chip_enable_n, host_bus_out, host_bus_oe_n,
    input  shared_addr_data_bus
  );
endinterface
`default_nettype wire

// ### verilog/mux_sram_device.sv
// Device end: address latches, 8K byte array and bus driver
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Address strobe rising edge captures bus byte
// - Low strobe rise loads address bits 7:0
// - High strobe rise loads address bits 12:8
// - Bus bits 7:5 ignored for high byte
// - Address bytes latch in either order
// - Latched bytes held until strobed again or cleared by reset
// - Host sets data before write strobe falls
// - Read strobe low drives addressed byte out
// - Host never asserts read and write together
// - Read/write need chip enable; strobes ungated
module mux_sram_device (
  input wire logic i_clock,
  input wire logic i_srst,
  mux_sram_if.device bus
);
  typedef struct packed {
    logic [7:0] lo_addr;
    logic [4:0] hi_addr;
    logic       las_d;
    logic       has_d;
    logic       wr_d;
    logic [7:0] bus_out;
    logic       bus_oe_n;
  } dev_state_t;

  dev_state_t  st_reg;
  dev_state_t  st_next;
  logic [7:0]  mem [mux_sram_pkg::MEM_DEPTH];
  logic [12:0] index;
  logic        wr_go;
  logic        rd_on;

  assign index = {st_reg.hi_addr, st_reg.lo_addr};
  // Write commits on the write strobe's rising edge, when data is settled
  assign wr_go = st_reg.wr_d && bus.write_strobe_n == 1'b1 &&
                 !bus.chip_enable_n;
  assign rd_on = !bus.read_strobe_n && !bus.chip_enable_n;

  always_comb begin
    st_next = st_reg;
    st_next.las_d = !bus.low_addr_strobe_n;
    st_next.has_d = !bus.high_addr_strobe_n;
    st_next.wr_d  = !bus.write_strobe_n && !bus.chip_enable_n;
    // Strobes act whatever chip enable says
    if (st_reg.las_d && bus.low_addr_strobe_n) begin
      st_next.lo_addr = bus.shared_addr_data_bus;
    end
    if (st_reg.has_d && bus.high_addr_strobe_n) begin
      st_next.hi_addr = bus.shared_addr_data_bus[4:0];
    end
    st_next.bus_oe_n = !rd_on;
    st_next.bus_out  = rd_on ? mem[index] : mux_sram_pkg::RESET_BYTE;
    if (i_srst) begin
      st_next = '0;
      st_next.bus_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    st_reg <= st_next;
  end

  // Array is not reset: contents survive like battery-backed cells
  always_ff @(posedge i_clock) begin
    if (wr_go && !i_srst) begin
      mem[index] <= bus.shared_addr_data_bus;
    end
  end

  assign bus.dev_bus_out  = st_reg.bus_out;
  assign bus.dev_bus_oe_n = st_reg.bus_oe_n;
endmodule
`default_nettype wire

// ### bench/mux_sram_properties.sv
// Pin-level assertions on the link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module mux_sram_properties (
  input wire logic       i_clock,
  input wire logic       i_srst,
  input wire logic       low_addr_strobe_n,
  input wire logic       high_addr_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       chip_enable_n,
  input wire logic       host_bus_oe_n,
  input wire logic [7:0] dev_bus_out,
  input wire logic       dev_bus_oe_n,
  input wire logic [7:0] shared_addr_data_bus
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_rd_go; !read_strobe_n && !chip_enable_n; endsequence
  sequence s_drv2; !dev_bus_oe_n ##1 !dev_bus_oe_n; endsequence
  sequence s_wr_hold;
    (!host_bus_oe_n && $stable(shared_addr_data_bus))[*8];
  endsequence
  property p_rd_drive; s_rd_go |=> !dev_bus_oe_n; endproperty
  property p_rd_steady; s_drv2 |-> $stable(dev_bus_out); endproperty
  property p_rd_off;
    (read_strobe_n || chip_enable_n) |=> dev_bus_oe_n;
  endproperty
  property p_wr_data; $fell(write_strobe_n) |-> s_wr_hold; endproperty
  property p_as_data;
    ($rose(low_addr_strobe_n) || $rose(high_addr_strobe_n)) |->
      !host_bus_oe_n && $stable(shared_addr_data_bus);
  endproperty
  property p_excl; read_strobe_n || write_strobe_n; endproperty
  property p_wr_ce; !write_strobe_n |-> !chip_enable_n; endproperty
  property p_no_fight; !dev_bus_oe_n |-> host_bus_oe_n; endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read not driven");
  a_rd_steady: assert property (p_rd_steady)
    else $error("read data moved");
  a_rd_off: assert property (p_rd_off)
    else $error("bus driven when idle");
  a_wr_data: assert property (p_wr_data)
    else $error("write data not held");
  a_as_data: assert property (p_as_data)
    else $error("address not on bus");
  a_excl: assert property (p_excl)
    else $error("read and write together");
  a_wr_ce: assert property (p_wr_ce)
    else $error("write without enable");
  a_no_fight: assert property (p_no_fight)
    else $error("bus contention");
endmodule
`default_nettype wire

// ### bench/muxed_bus_sram_access_tb.sv
// Bench: host and device joined, plus a device driven pin by pin
`timescale 1ns/100ps
`default_nettype none
module muxed_bus_sram_access_tb;
  logic        i_clock, i_srst, i_req, i_write, i_skip_hi, i_skip_lo;
  logic        i_hi_first, o_busy, o_done;
  logic [12:0] i_addr;
  logic [7:0]  i_wdata, o_rdata;
  int          n_fail, n_tests;
  // Row: write, address, data, skip_hi, skip_lo, hi_first
  logic [24:0] rows [10] = '{
    {1'b1, 13'h1fff, 8'ha5, 3'b000}, {1'b1, 13'h0000, 8'h5a, 3'b001},
    {1'b1, 13'h00ff, 8'h3c, 3'b000}, {1'b1, 13'h1f00, 8'hc3, 3'b001},
    {1'b0, 13'h1fff, 8'ha5, 3'b001}, {1'b0, 13'h0000, 8'h5a, 3'b000},
    {1'b0, 13'h00ff, 8'h3c, 3'b001}, {1'b0, 13'h1f00, 8'hc3, 3'b000},
    {1'b0, 13'h00ff, 8'ha5, 3'b100}, {1'b0, 13'h0000, 8'h3c, 3'b010}};
  // Pins: low, high, read, write, enable strobes, host oe_n; bus byte
  logic [13:0] steps [8] = '{
    {6'h2e, 8'hff}, {6'h3e, 8'hff}, {6'h1e, 8'h00}, {6'h3e, 8'h00},
    {6'h38, 8'h99}, {6'h3c, 8'h99}, {6'h3a, 8'h77}, {6'h3e, 8'h77}};
  mux_sram_if m ();
  mux_sram_if p ();
  mux_sram_host mux_sram_host_inst (.i_clock, .i_srst, .i_req, .i_write,
    .i_addr, .i_wdata, .i_skip_hi, .i_skip_lo, .i_hi_first, .o_busy,
    .o_done, .o_rdata, .bus(m));
  mux_sram_device mux_sram_device_inst (.i_clock, .i_srst, .bus(m));
  mux_sram_device pin_dev (.i_clock, .i_srst, .bus(p));
  mux_sram_properties mux_sram_properties_inst (.i_clock, .i_srst,
    .low_addr_strobe_n(m.low_addr_strobe_n),
    .high_addr_strobe_n(m.high_addr_strobe_n),
    .read_strobe_n(m.read_strobe_n), .write_strobe_n(m.write_strobe_n),
    .chip_enable_n(m.chip_enable_n), .host_bus_oe_n(m.host_bus_oe_n),
    .dev_bus_out(m.dev_bus_out), .dev_bus_oe_n(m.dev_bus_oe_n),
    .shared_addr_data_bus(m.shared_addr_data_bus));
  task automatic chk_ok(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic pin(input logic [13:0] s);
    @(negedge i_clock);
    {p.low_addr_strobe_n, p.high_addr_strobe_n, p.read_strobe_n,
     p.write_strobe_n, p.chip_enable_n, p.host_bus_oe_n} = s[13:8];
    p.host_bus_out = s[7:0];
  endtask
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    #40000;
    chk_ok(1'b0, "timeout");
    conclude();
  end
  initial begin
    {i_srst, i_req, i_write, i_addr, i_wdata} = {1'b1, 23'h0};
    {i_skip_hi, i_skip_lo, i_hi_first} = 3'b000;
    {p.host_bus_out, p.host_bus_oe_n} = 9'h1ff;
    {p.low_addr_strobe_n, p.high_addr_strobe_n, p.read_strobe_n} = 3'h7;
    {p.write_strobe_n, p.chip_enable_n} = 2'h3;
    repeat (5) @(negedge i_clock);
    i_srst = 1'b0;
    chk_ok(m.chip_enable_n === 1'b1 && m.dev_bus_oe_n === 1'b1, "rst pins");
    chk_ok(o_busy === 1'b0 && o_done === 1'b0, "rst host");
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clock);
      {i_write, i_addr, i_wdata, i_skip_hi, i_skip_lo, i_hi_first} = rows[i];
      i_req = 1'b1;
      @(negedge i_clock);
      i_req = 1'b0;
      chk_ok(o_busy === 1'b1, "not busy");
      for (int k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_clock);
      chk_ok(o_done === 1'b1, "no done");
      if (!rows[i][24]) begin
        chk_ok(o_rdata === rows[i][10:3], "rd data");
      end
      @(negedge i_clock);
      chk_ok(o_done === 1'b0 && o_busy === 1'b0, "done stuck");
      $display("row %0d done", i);
    end
    // Upper strobe sees ff, one enabled write, then one with enable high
    foreach (steps[j]) pin(steps[j]);
    pin({6'h37, 8'h00});
    pin({6'h35, 8'h00});
    chk_ok(p.dev_bus_oe_n === 1'b1, "read without enable");
    @(negedge i_clock);
    chk_ok(p.shared_addr_data_bus === 8'h99, "pin read");
    $display("pin test done");
    // Reset in mid-write must cut it: the old byte has to survive
    @(negedge i_clock);
    {i_write, i_addr, i_wdata, i_skip_hi, i_skip_lo, i_hi_first} =
      {1'b1, 13'h0000, 8'hee, 3'b000};
    i_req = 1'b1;
    @(negedge i_clock);
    i_req = 1'b0;
    repeat (40) @(negedge i_clock);
    i_srst = 1'b1;
    repeat (5) @(negedge i_clock);
    i_srst = 1'b0;
    chk_ok(m.write_strobe_n === 1'b1 && m.chip_enable_n === 1'b1,
      "cut pins");
    chk_ok(o_busy === 1'b0 && m.dev_bus_oe_n === 1'b1, "cut busy");
    // Both bytes skipped: the index comes from latches cleared by reset
    {i_write, i_skip_hi, i_skip_lo} = 3'b011;
    i_req = 1'b1;
    @(negedge i_clock);
    i_req = 1'b0;
    for (int k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_clock);
    chk_ok(o_done === 1'b1 && o_rdata === 8'h5a, "cut write");
    $display("mid reset test done");
    conclude();
  end
endmodule
`default_nettype wire
